// [pkg/lbc_pkg.sv]
// lbc_pkg: constants, field layouts and types of the line bank config block.
// assumes one 100 MHz clock (pclk) that is also the master clock of the line unit.
package lbc_pkg;

  // clock and channel count
  localparam int unsigned CLK_MHZ    = 100;
  localparam int unsigned NUM_CHAN   = 16;
  localparam int unsigned BANK_CHAN  = 8;

  // printed register indices; byte address is four times the index
  localparam logic [7:0]  IDX_MON_UP      = 8'h2B;
  localparam logic [7:0]  IDX_LOOP_LO     = 8'h0C;
  localparam logic [7:0]  IDX_CRIT_LO     = 8'h0D;
  localparam logic [7:0]  IDX_ONES_LO     = 8'h0E;
  localparam logic [7:0]  IDX_GCFG_LO     = 8'h0F;
  localparam logic [7:0]  IDX_LOOP_UP     = 8'h2C;
  localparam logic [7:0]  IDX_CRIT_UP     = 8'h2D;
  localparam logic [7:0]  IDX_ONES_UP     = 8'h2E;
  localparam logic [7:0]  IDX_GCFG_UP     = 8'h2F;

  // byte-address map of the bus
  localparam logic [11:0] ADDR_MON_UP     = {2'b00, IDX_MON_UP, 2'b00};
  localparam logic [11:0] ADDR_LOOP_LO    = {2'b00, IDX_LOOP_LO, 2'b00};
  localparam logic [11:0] ADDR_CRIT_LO    = {2'b00, IDX_CRIT_LO, 2'b00};
  localparam logic [11:0] ADDR_ONES_LO    = {2'b00, IDX_ONES_LO, 2'b00};
  localparam logic [11:0] ADDR_GCFG_LO    = {2'b00, IDX_GCFG_LO, 2'b00};
  localparam logic [11:0] ADDR_LOOP_UP    = {2'b00, IDX_LOOP_UP, 2'b00};
  localparam logic [11:0] ADDR_CRIT_UP    = {2'b00, IDX_CRIT_UP, 2'b00};
  localparam logic [11:0] ADDR_ONES_UP    = {2'b00, IDX_ONES_UP, 2'b00};
  localparam logic [11:0] ADDR_GCFG_UP    = {2'b00, IDX_GCFG_UP, 2'b00};
  // per-channel settings: eight 16-bit words from this base, then status
  localparam logic [11:0] ADDR_CHAN_BASE  = 12'h100;
  localparam int unsigned NUM_CHAN_REG    = 8;
  localparam logic [11:0] ADDR_CAL_STAT   = 12'h120;
  localparam int unsigned CAL_STAT_BIT    = 4;

  // per-channel word order
  localparam int unsigned CH_ALARM   = 0;
  localparam int unsigned CH_SHORT   = 1;
  localparam int unsigned CH_CODE    = 2;
  localparam int unsigned CH_DEPTH   = 3;
  localparam int unsigned CH_POS     = 4;
  localparam int unsigned CH_JEN     = 5;
  localparam int unsigned CH_MATCH   = 6;
  localparam int unsigned CH_E1      = 7;

  // reset values
  localparam logic [7:0]  REG8_RST   = 8'h00;
  localparam logic [15:0] REG16_RST  = 16'h0000;

  // calibration cycle length
  localparam int unsigned CAL_TIME_NS = 640;
  localparam int unsigned CAL_CYCLES  = CAL_TIME_NS * CLK_MHZ / 1000;
  localparam logic [6:0]  CAL_LAST    = 7'(CAL_CYCLES - 1);

  // monitor select field
  localparam logic [3:0]  MON_TX_BIT_MASK = 4'h8;
  localparam logic [4:0]  MON_CHAN_BASE   = 5'h09;

  // global configuration layout, bit 7 down to bit 0
  typedef struct packed {
    logic rx_match_mode_select;
    logic alarm_on_loss_global;
    logic short_protect_disable;
    logic code_ami;
    logic jitter_depth_select;
    logic calib_bit;
    logic jitter_position_select;
    logic jitter_atten_enable;
  } lbc_gcfg_s;

  // monitor routing
  typedef struct packed {
    logic       enable;
    logic       is_tx;
    logic [4:0] chan;
  } lbc_mon_s;

  typedef enum logic [0:0] {
    CAL_IDLE = 1'b0,
    CAL_RUN  = 1'b1
  } lbc_cal_e;

endpackage : lbc_pkg

// [logic/lbc_bank_config.sv]
// lbc_bank_config: register bank and per-channel control of a 16-channel line unit.
// assumes an APB master on pclk, and that pclk is the master clock of the line unit.
//
// Chosen here: the APB slave port.
`timescale 1ns/1ps
`default_nettype none

module lbc_bank_config
  import lbc_pkg::*;
(
  input  wire logic               pclk,
  input  wire logic               presetn,
  input  wire logic               psel,
  input  wire logic               penable,
  input  wire logic               pwrite,
  input  wire logic [11:0]        paddr,
  input  wire logic [31:0]        pwdata,
  output logic      [31:0]        prdata,
  output logic                    pready,
  output logic                    pslverr,
  input  wire logic [15:0]        los_detect,
  input  wire logic [15:0]        tx_pos_enc,
  input  wire logic [15:0]        tx_neg_enc,
  input  wire logic [15:0]        line_pos_dec,
  input  wire logic [15:0]        line_neg_dec,
  output logic      [15:0]        rx_pos_out,
  output logic      [15:0]        rx_neg_out,
  output logic      [15:0]        loopback_on,
  output logic      [15:0]        ets_criteria,
  output logic      [15:0]        t1_criteria,
  output logic      [15:0]        ami_code,
  output logic      [15:0]        ais_send,
  output logic      [15:0]        tx_all_ones,
  output logic      [15:0]        short_protect_off,
  output logic      [15:0]        ja_enable,
  output logic      [15:0]        ja_in_rx,
  output logic      [15:0]        ja_depth128,
  output logic      [15:0]        rx_internal_match,
  output logic      [15:0]        rx_ext_trim,
  output lbc_mon_s                monitor,
  output logic                    cal_busy
);

  // register state
  logic      [3:0]  mon_q,    mon_d;
  logic      [7:0]  loop_lo_q, loop_lo_d, loop_up_q, loop_up_d;
  logic      [7:0]  crit_lo_q, crit_lo_d, crit_up_q, crit_up_d;
  logic      [7:0]  ones_lo_q, ones_lo_d, ones_up_q, ones_up_d;
  lbc_gcfg_s        gcfg_lo_q, gcfg_lo_d, gcfg_up_q, gcfg_up_d;
  logic      [15:0] chan_q [NUM_CHAN_REG];
  logic      [15:0] chan_d [NUM_CHAN_REG];
  logic             pready_q, pready_d, pslverr_q, pslverr_d;
  logic      [31:0] prdata_q, prdata_d;
  lbc_cal_e         cal_q,    cal_d;
  logic      [6:0]  cnt_q,    cnt_d;
  logic             wr_go, rd_hit, cal_start;
  logic      [11:0] chan_off;

  // write commits on the edge where pready is sampled high
  assign wr_go    = psel & penable & pready_q & pwrite;
  assign chan_off = paddr - ADDR_CHAN_BASE;

  // address decode and read mux, one wait state before pready
  always_comb begin
    prdata_d  = prdata_q;
    pslverr_d = 1'b0;
    rd_hit    = 1'b1;
    pready_d  = psel & penable & ~pready_q;
    case (paddr)
      ADDR_MON_UP:   prdata_d = {28'h0000000, mon_q};
      ADDR_LOOP_LO:  prdata_d = {24'h000000, loop_lo_q};
      ADDR_CRIT_LO:  prdata_d = {24'h000000, crit_lo_q};
      ADDR_ONES_LO:  prdata_d = {24'h000000, ones_lo_q};
      ADDR_GCFG_LO:  prdata_d = {24'h000000, gcfg_lo_q};
      ADDR_LOOP_UP:  prdata_d = {24'h000000, loop_up_q};
      ADDR_CRIT_UP:  prdata_d = {24'h000000, crit_up_q};
      ADDR_ONES_UP:  prdata_d = {24'h000000, ones_up_q};
      ADDR_GCFG_UP:  prdata_d = {24'h000000, gcfg_up_q};
      ADDR_CAL_STAT: begin
        prdata_d               = 32'h00000000;
        prdata_d[CAL_STAT_BIT] = gcfg_lo_q.calib_bit & cal_busy;
      end
      default: begin
        if (paddr >= ADDR_CHAN_BASE && paddr < ADDR_CAL_STAT && paddr[1:0] == 2'b00) begin
          prdata_d = {16'h0000, chan_q[chan_off[4:2]]};
        end else begin
          rd_hit = 1'b0;
        end
      end
    endcase
    if (!pready_d) begin
      prdata_d = prdata_q;
    end else if (!rd_hit) begin
      prdata_d  = 32'h00000000;
      pslverr_d = 1'b1;
    end
  end

  // register writes; status word and unmapped words ignore writes
  always_comb begin
    mon_d     = mon_q;
    loop_lo_d = loop_lo_q;
    crit_lo_d = crit_lo_q;
    ones_lo_d = ones_lo_q;
    gcfg_lo_d = gcfg_lo_q;
    loop_up_d = loop_up_q;
    crit_up_d = crit_up_q;
    ones_up_d = ones_up_q;
    gcfg_up_d = gcfg_up_q;
    for (int i = 0; i < NUM_CHAN_REG; i++) begin
      chan_d[i] = chan_q[i];
    end
    if (wr_go) begin
      case (paddr)
        ADDR_MON_UP:  mon_d     = pwdata[3:0];
        ADDR_LOOP_LO: loop_lo_d = pwdata[7:0];
        ADDR_CRIT_LO: crit_lo_d = pwdata[7:0];
        ADDR_ONES_LO: ones_lo_d = pwdata[7:0];
        ADDR_GCFG_LO: gcfg_lo_d = pwdata[7:0];
        ADDR_LOOP_UP: loop_up_d = pwdata[7:0];
        ADDR_CRIT_UP: crit_up_d = pwdata[7:0];
        ADDR_ONES_UP: ones_up_d = pwdata[7:0];
        ADDR_GCFG_UP: gcfg_up_d = pwdata[7:0];
        default: begin
          if (paddr >= ADDR_CHAN_BASE && paddr < ADDR_CAL_STAT && paddr[1:0] == 2'b00) begin
            chan_d[chan_off[4:2]] = pwdata[15:0];
          end
        end
      endcase
    end
  end

  assign cal_start = wr_go && paddr == ADDR_GCFG_LO && !gcfg_lo_q.calib_bit
                     && pwdata[2] && gcfg_up_q.calib_bit;

  // calibration sequencer; a new rise during a cycle restarts the count
  always_comb begin
    cal_d = cal_q;
    cnt_d = cnt_q;
    case (cal_q)
      CAL_IDLE: begin
        if (cal_start) begin
          cal_d = CAL_RUN;
          cnt_d = 7'h00;
        end
      end
      CAL_RUN: begin
        if (cal_start) begin
          cnt_d = 7'h00;
        end else if (cnt_q == CAL_LAST) begin
          cal_d = CAL_IDLE;
        end else begin
          cnt_d = cnt_q + 7'h01;
        end
      end
      default: cal_d = CAL_IDLE;
    endcase
  end

  // bus and register flops, all clear at reset
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      mon_q     <= 4'h0;
      loop_lo_q <= REG8_RST;
      crit_lo_q <= REG8_RST;
      ones_lo_q <= REG8_RST;
      gcfg_lo_q <= REG8_RST;
      loop_up_q <= REG8_RST;
      crit_up_q <= REG8_RST;
      ones_up_q <= REG8_RST;
      gcfg_up_q <= REG8_RST;
      for (int i = 0; i < NUM_CHAN_REG; i++) begin
        chan_q[i] <= REG16_RST;
      end
      pready_q  <= 1'b0;
      pslverr_q <= 1'b0;
      prdata_q  <= 32'h00000000;
      cal_q     <= CAL_IDLE;
      cnt_q     <= 7'h00;
    end else begin
      mon_q     <= mon_d;
      loop_lo_q <= loop_lo_d;
      crit_lo_q <= crit_lo_d;
      ones_lo_q <= ones_lo_d;
      gcfg_lo_q <= gcfg_lo_d;
      loop_up_q <= loop_up_d;
      crit_up_q <= crit_up_d;
      ones_up_q <= ones_up_d;
      gcfg_up_q <= gcfg_up_d;
      for (int i = 0; i < NUM_CHAN_REG; i++) begin
        chan_q[i] <= chan_d[i];
      end
      pready_q  <= pready_d;
      pslverr_q <= pslverr_d;
      prdata_q  <= prdata_d;
      cal_q     <= cal_d;
      cnt_q     <= cnt_d;
    end
  end

  assign prdata   = prdata_q;
  assign pready   = pready_q;
  assign pslverr  = pslverr_q;
  assign cal_busy = (cal_q == CAL_RUN);

  lbc_mon_s mon_n;
  always_comb begin
    mon_n.enable = (mon_q[2:0] != 3'b000);
    mon_n.is_tx  = |(mon_q & MON_TX_BIT_MASK);
    mon_n.chan   = mon_n.enable ? MON_CHAN_BASE + {2'b00, mon_q[2:0]} : 5'h00;
  end

  // per-channel resolution of global and per-channel settings
  logic [15:0] loop_all, crit_all, ones_all;
  logic [15:0] rxp_n, rxn_n, lb_n, ets_n, t1_n, ami_n, ais_n, ones_n, scp_n;
  logic [15:0] jen_n, jrx_n, jdp_n, imt_n, trm_n;
  assign loop_all = {loop_up_q, loop_lo_q};
  assign crit_all = {crit_up_q, crit_lo_q};
  assign ones_all = {ones_up_q, ones_lo_q};

  for (genvar c = 0; c < NUM_CHAN; c++) begin : g_chan
    lbc_gcfg_s g;
    logic      lower;
    assign lower = (c < BANK_CHAN);
    assign g     = lower ? gcfg_lo_q : gcfg_up_q;
    // loop encoded transmit rails to receive rails
    assign rxp_n[c] = loop_all[c] ? tx_pos_enc[c] : line_pos_dec[c];
    assign rxn_n[c] = loop_all[c] ? tx_neg_enc[c] : line_neg_dec[c];
    assign lb_n[c]  = loop_all[c];
    assign ets_n[c] = chan_q[CH_E1][c] & crit_all[c];
    assign t1_n[c]  = ~chan_q[CH_E1][c];
    assign ami_n[c] = g.code_ami | chan_q[CH_CODE][c];
    assign ais_n[c] = los_detect[c] & (g.alarm_on_loss_global | chan_q[CH_ALARM][c]);
    assign ones_n[c] = los_detect[c] & ones_all[c];
    assign scp_n[c] = g.short_protect_disable | chan_q[CH_SHORT][c];
    assign jen_n[c] = g.jitter_atten_enable | chan_q[CH_JEN][c];
    assign jrx_n[c] = g.jitter_position_select |
                      (chan_q[CH_POS][c] & ~(lower & g.jitter_atten_enable));
    assign jdp_n[c] = g.jitter_depth_select | chan_q[CH_DEPTH][c];
    assign imt_n[c] = g.rx_match_mode_select;
    assign trm_n[c] = ~g.rx_match_mode_select & chan_q[CH_MATCH][c];
  end

  // output flops; the all-ones drive runs on pclk, the master clock
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      rx_pos_out        <= 16'h0000;
      rx_neg_out        <= 16'h0000;
      loopback_on       <= 16'h0000;
      ets_criteria      <= 16'h0000;
      t1_criteria       <= 16'h0000;
      ami_code          <= 16'h0000;
      ais_send          <= 16'h0000;
      tx_all_ones       <= 16'h0000;
      short_protect_off <= 16'h0000;
      ja_enable         <= 16'h0000;
      ja_in_rx          <= 16'h0000;
      ja_depth128       <= 16'h0000;
      rx_internal_match <= 16'h0000;
      rx_ext_trim       <= 16'h0000;
      monitor           <= '0;
    end else begin
      rx_pos_out        <= rxp_n;
      rx_neg_out        <= rxn_n;
      loopback_on       <= lb_n;
      ets_criteria      <= ets_n;
      t1_criteria       <= t1_n;
      ami_code          <= ami_n;
      ais_send          <= ais_n;
      tx_all_ones       <= ones_n;
      short_protect_off <= scp_n;
      ja_enable         <= jen_n;
      ja_in_rx          <= jrx_n;
      ja_depth128       <= jdp_n;
      rx_internal_match <= imt_n;
      rx_ext_trim       <= trm_n;
      monitor           <= mon_n;
    end
  end

  // checks
  default clocking cb @(posedge pclk); endclocking
  default disable iff (!presetn);

  AST_MON_TX: assert property (wr_go && paddr == ADDR_MON_UP
    && pwdata[3:0] == 4'hC |=> ##1 monitor.enable && monitor.is_tx && monitor.chan == 5'h0D)
    else $error("monitor code C not routed to transmitter 13");
  AST_MON_NONE: assert property (wr_go && paddr == ADDR_MON_UP
    && pwdata[2:0] == 3'b000 |=> ##1 !monitor.enable)
    else $error("monitor enabled for a no-monitoring code");
  AST_LOOP: assert property (loop_all[0] |=> rx_pos_out[0] == $past(tx_pos_enc[0]))
    else $error("loopback channel 1 not carrying transmit data");
  AST_ONES: assert property (ones_all[9] && los_detect[9] |=> tx_all_ones[9])
    else $error("all ones not sent on loss");
  AST_AIS_GLOBAL: assert property (gcfg_up_q.alarm_on_loss_global && los_detect[12]
    |=> ais_send[12])
    else $error("global alarm on loss not applied");
  AST_BANK_SPLIT: assert property (gcfg_lo_q.code_ami && !chan_q[CH_CODE][10]
    && !gcfg_up_q.code_ami |=> !ami_code[10])
    else $error("lower global bit leaked to upper bank");
  AST_CAL_PERMIT: assert property (wr_go && paddr == ADDR_GCFG_LO && pwdata[2]
    && !gcfg_lo_q.calib_bit && !gcfg_up_q.calib_bit && !cal_busy |=> !cal_busy)
    else $error("calibration started without permit");
  AST_CAL_START: assert property (cal_start |=> cal_busy [*8])
    else $error("calibration cycle not running after trigger rise");
  AST_CAL_END: assert property ($rose(cal_busy) |-> ##[1:70] !cal_busy)
    else $error("calibration cycle did not finish in time");
  AST_JPOS_LO: assert property (gcfg_lo_q.jitter_atten_enable
    && !gcfg_lo_q.jitter_position_select |=> !ja_in_rx[2])
    else $error("per-channel position used while global enable set");
  AST_DEPTH: assert property (gcfg_up_q.jitter_depth_select |=> ja_depth128[15])
    else $error("global depth not forced");
  AST_READBACK: assert property (psel && penable && !pwrite && pready_q
    && paddr == ADDR_CRIT_UP |-> prdata_q[7:0] == crit_up_q)
    else $error("register read did not return stored value");
  AST_STAT: assert property (cal_busy && gcfg_lo_q.calib_bit && pready_d
    && paddr == ADDR_CAL_STAT |=> prdata[CAL_STAT_BIT])
    else $error("calibration progress not reported");
  AST_T1_MODE: assert property (!chan_q[CH_E1][12] |=> t1_criteria[12])
    else $error("T1 criteria not selected outside E1 mode");
  AST_SHORT: assert property (gcfg_lo_q.short_protect_disable |=> short_protect_off[0])
    else $error("global short protect disable not applied");
  AST_MATCH: assert property (gcfg_up_q.rx_match_mode_select
    |=> rx_internal_match[9] && !rx_ext_trim[9])
    else $error("internal match mode not applied");

  COV_CAL: cover property (cal_start ##1 cal_busy [*8]);
  COV_LOOP: cover property (loop_all[0] && loopback_on[0]);
  COV_ERR: cover property (pslverr && pready);
  COV_ONES: cover property (tx_all_ones[15]);
  COV_MON_TX: cover property (monitor.enable && monitor.is_tx);

endmodule : lbc_bank_config

`default_nettype wire

// [bench/test_lbc_bank_config.sv]
// test_lbc_bank_config: self-checking bench for the line bank config block.
// assumes APB with one wait state; all per-channel outputs lag by one pclk edge.
`timescale 1ns/1ps
`default_nettype none
`define CHK(nm, exp, got) begin checks++; if ((got) !== (exp)) begin fail_count++; \
  $display("Error %s expected %h seen %h", nm, exp, got); end end
module test_lbc_bank_config;
  import lbc_pkg::*;
  logic        pclk, presetn, psel, penable, pwrite, pready, pslverr, cal_busy;
  logic [11:0] paddr;
  logic [31:0] pwdata, prdata, rd;
  logic [15:0] los_detect, tx_pos_enc, tx_neg_enc, line_pos_dec, line_neg_dec;
  logic [15:0] rx_pos_out, rx_neg_out, loopback_on, ets_criteria, t1_criteria, ami_code;
  logic [15:0] ais_send, tx_all_ones, short_protect_off, ja_enable, ja_in_rx, ja_depth128;
  logic [15:0] rx_internal_match, rx_ext_trim, lb;
  lbc_mon_s    monitor;
  logic        er;
  int          fail_count, checks, pk;
  logic [11:0] regs [9];

  lbc_bank_config uut (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
    .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
    .pslverr(pslverr), .los_detect(los_detect), .tx_pos_enc(tx_pos_enc),
    .tx_neg_enc(tx_neg_enc), .line_pos_dec(line_pos_dec), .line_neg_dec(line_neg_dec),
    .rx_pos_out(rx_pos_out), .rx_neg_out(rx_neg_out), .loopback_on(loopback_on),
    .ets_criteria(ets_criteria), .t1_criteria(t1_criteria), .ami_code(ami_code),
    .ais_send(ais_send), .tx_all_ones(tx_all_ones), .short_protect_off(short_protect_off),
    .ja_enable(ja_enable), .ja_in_rx(ja_in_rx), .ja_depth128(ja_depth128),
    .rx_internal_match(rx_internal_match), .rx_ext_trim(rx_ext_trim), .monitor(monitor),
    .cal_busy(cal_busy));

  // free-running 100 MHz clock
  initial begin
    pclk = 1'b0;
    forever #5 pclk = ~pclk;
  end

  task automatic tick(input int n);
    repeat (n) @(posedge pclk);
  endtask : tick

  // one apb transfer; request held until pready is sampled high
  task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] d);
    int n;
    n = 0;
    @(posedge pclk);
    psel <= 1'b1; penable <= 1'b0; pwrite <= w; paddr <= a; pwdata <= d;
    @(posedge pclk);
    penable <= 1'b1;
    do begin @(posedge pclk); n++; end while (pready !== 1'b1 && n < 50);
    rd = prdata;
    er = pslverr;
    if (n >= 50) begin fail_count++; $display("Error pready expected 1 seen 0"); end
    psel <= 1'b0; penable <= 1'b0;
  endtask : apb

  task automatic wr(input logic [11:0] a, input logic [31:0] d);
    apb(1'b1, a, d);
    tick(2); // let registered outputs settle
  endtask : wr

  // output vector governed by one global config bit
  function automatic logic [15:0] pick(input int b);
    case (b)
      0: pick = ja_enable;
      1: pick = ja_in_rx;
      3: pick = ja_depth128;
      4: pick = ami_code;
      5: pick = short_protect_off;
      6: pick = ais_send;
      default: pick = rx_internal_match;
    endcase
  endfunction : pick

  task automatic wrap_up;
    $display("checks %0d mismatches %0d", checks, fail_count);
    if (fail_count == 0 && checks > 0) begin
      $display("*** PASS ***");
    end else begin
      $display("*** FAIL ***");
    end
    $finish;
  endtask : wrap_up

  // watchdog, tests need about 1100 cycles
  initial begin
    tick(20000);
    fail_count++;
    $display("Error watchdog expected done seen timeout");
    wrap_up();
  end

  initial begin
    regs = '{ADDR_LOOP_LO, ADDR_CRIT_LO, ADDR_ONES_LO, ADDR_GCFG_LO, ADDR_LOOP_UP,
             ADDR_CRIT_UP, ADDR_ONES_UP, ADDR_GCFG_UP, ADDR_MON_UP};
    presetn = 1'b0; psel = 1'b0; penable = 1'b0; pwrite = 1'b0; paddr = '0; pwdata = '0;
    los_detect = '0; tx_pos_enc = 16'hAAAA; tx_neg_enc = 16'h5555;
    line_pos_dec = 16'h0F0F; line_neg_dec = 16'hF0F0;
    fail_count = 0; checks = 0;
    tick(3);
    presetn <= 1'b1;
    // reset values, then readback with upper bits dropped
    for (int i = 0; i < 9; i++) begin
      apb(1'b0, regs[i], '0);
      `CHK("reset value", 32'h0000_0000, rd)
      apb(1'b1, regs[i], 32'hFFFF_FF5A);
      apb(1'b0, regs[i], '0);
      `CHK("readback", (i == 8) ? 32'h0000_000A : 32'h0000_005A, rd)
      apb(1'b1, regs[i], '0);
    end
    apb(1'b1, 12'h040, 32'h0000_00FF);
    `CHK("unmapped write error", 1'b1, er)
    apb(1'b0, 12'h040, '0);
    `CHK("unmapped read data", 32'h0000_0000, rd)
    $display("test registers done");
    // every monitor code
    for (int c = 0; c < 16; c++) begin
      wr(ADDR_MON_UP, 32'(c));
      `CHK("monitor enable", c[2:0] != 3'h0, monitor.enable)
      `CHK("monitor chan", (c[2:0] != 3'h0) ? 5'(9 + c[2:0]) : 5'h00, monitor.chan)
      if (c[2:0] != 3'h0) `CHK("monitor tx", c[3], monitor.is_tx)
    end
    $display("test monitor done");
    // loopback on channels 1 and 16, attenuator on receive side of channel 1
    lb = 16'h8001;
    wr(ADDR_LOOP_LO, 32'h01);
    wr(ADDR_LOOP_UP, 32'h80);
    wr(ADDR_CHAN_BASE + 12'h010, 32'h0001);
    `CHK("loopback_on", lb, loopback_on)
    `CHK("rx_pos_out", (tx_pos_enc & lb) | (line_pos_dec & ~lb), rx_pos_out)
    `CHK("rx_neg_out", (tx_neg_enc & lb) | (line_neg_dec & ~lb), rx_neg_out)
    `CHK("ja_in_rx loop", 16'h0001, ja_in_rx)
    wr(ADDR_CHAN_BASE + 12'h010, 32'h0000);
    // criteria per channel, E1 on low eight
    wr(ADDR_CHAN_BASE + 12'h01C, 32'h00FF);
    wr(ADDR_CRIT_LO, 32'h0F);
    wr(ADDR_CRIT_UP, 32'h0F);
    `CHK("ets_criteria", 16'h000F, ets_criteria)
    `CHK("t1_criteria", 16'hFF00, t1_criteria)
    // all ones only where loss and select meet
    @(posedge pclk) los_detect <= 16'h0105;
    wr(ADDR_ONES_LO, 32'h03);
    wr(ADDR_ONES_UP, 32'h03);
    `CHK("tx_all_ones", 16'h0101, tx_all_ones)
    $display("test channel done");
    // each global bit except the calibration bit acts on its own bank only
    @(posedge pclk) los_detect <= 16'hFFFF;
    for (int bk = 0; bk < 2; bk++) begin
      lb = bk ? 16'hFF00 : 16'h00FF;
      for (int b = 0; b < 8; b++) begin
        if (b == 2) continue;
        wr(bk ? ADDR_GCFG_UP : ADDR_GCFG_LO, 32'(1 << b));
        `CHK("global bit", lb, pick(b))
      end
      wr(bk ? ADDR_GCFG_UP : ADDR_GCFG_LO, 32'h00);
    end
    // clear global bits leave each channel to its own word
    for (int k = 0; k < 6; k++) begin
      if (k == 4) continue;
      pk = (k == 0) ? 6 : (k == 1) ? 5 : (k == 2) ? 4 : (k == 3) ? 3 : 0;
      wr(ADDR_CHAN_BASE + 12'(4 * k), 32'h0000_1234);
      `CHK("channel word", 16'h1234, pick(pk))
      wr(ADDR_CHAN_BASE + 12'(4 * k), 32'h0000_0000);
    end
    // lower enable masks per-channel position, lower match-on clears external trim
    wr(ADDR_CHAN_BASE + 12'h010, 32'hFFFF);
    wr(ADDR_CHAN_BASE + 12'h018, 32'hFFFF);
    wr(ADDR_GCFG_LO, 32'h81);
    `CHK("ja_in_rx masked", 16'hFF00, ja_in_rx)
    `CHK("rx_ext_trim", 16'hFF00, rx_ext_trim)
    wr(ADDR_GCFG_LO, 32'h00);
    `CHK("ja_in_rx free", 16'hFFFF, ja_in_rx)
    $display("test global done");
    // trigger without permit does nothing
    wr(ADDR_GCFG_LO, 32'h04);
    `CHK("cal no permit", 1'b0, cal_busy)
    wr(ADDR_GCFG_LO, 32'h00);
    // permit, wait 5 us, then trigger
    wr(ADDR_GCFG_UP, 32'h04);
    tick(500);
    wr(ADDR_GCFG_LO, 32'h04);
    `CHK("cal busy", 1'b1, cal_busy)
    apb(1'b0, ADDR_CAL_STAT, '0);
    `CHK("cal status", 1'b1, rd[CAL_STAT_BIT])
    tick(CAL_CYCLES + 4);
    `CHK("cal done", 1'b0, cal_busy)
    apb(1'b0, ADDR_CAL_STAT, '0);
    `CHK("cal status done", 1'b0, rd[CAL_STAT_BIT])
    $display("test calibration done");
    wrap_up();
  end
endmodule : test_lbc_bank_config
`undef CHK
`default_nettype wire
